// ==== hw/rfc_pkg.sv ====
// Constants, register map and flag layout for the reset-cause flag block.
package rfc_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] RFC_OFS_CAUSE_A    = 8'h00;
	localparam logic [7:0] RFC_OFS_CAUSE_B    = 8'h04;
	localparam logic [7:0] RFC_OFS_CAUSE_C    = 8'h08;
	localparam logic [7:0] RFC_OFS_IWD_CFG    = 8'h0c;
	localparam logic [7:0] RFC_OFS_WWD_CFG    = 8'h10;
	localparam logic [7:0] RFC_OFS_IWD_REFRSH = 8'h14;
	localparam logic [7:0] RFC_OFS_WWD_REFRSH = 8'h18;

	// ------------------------------------------------------------
	// Flag positions
	// ------------------------------------------------------------
	localparam int RFC_A_W = 5;
	localparam int RFC_B_W = 10;
	localparam int A_POWER_ON   = 0;
	localparam int A_VMON0      = 1;
	localparam int A_VMON1      = 2;
	localparam int A_VMON2      = 3;
	localparam int A_DEEP_STBY  = 4;
	localparam int B_INDEP_WDOG = 0;
	localparam int B_WIN_WDOG   = 1;
	localparam int B_SOFT       = 2;
	localparam int B_RAM_PAR    = 3;
	localparam int B_RAM_ECC    = 4;
	localparam int B_BUS_SLAVE  = 5;
	localparam int B_BUS_MASTER = 6;
	localparam int B_STACK_PTR  = 7;
	localparam int B_SEC_STATE  = 8;
	localparam int B_CACHE_PAR  = 9;
	localparam int C_COLD_WARM  = 0;

	localparam logic [RFC_A_W-1:0] RFC_A_RESET    = 5'h01;
	localparam logic [RFC_B_W-1:0] RFC_B_RESET    = 10'h000;
	localparam logic               RFC_C_RESET    = 1'b0;
	localparam logic [RFC_A_W-1:0] RFC_A_PIN_CLR  = 5'h1f;
	localparam logic [RFC_B_W-1:0] RFC_B_PIN_COMN = 10'h04f;
	localparam logic [RFC_B_W-1:0] RFC_B_ONLY_V1  = 10'h0a0;
	localparam logic [RFC_B_W-1:0] RFC_B_ONLY_V2  = 10'h310;
	localparam logic [RFC_B_W-1:0] RFC_B_COMMON   = 10'h04f;

	// ------------------------------------------------------------
	// Watchdog settings
	// ------------------------------------------------------------
	localparam int RFC_WD_W = 16;
	localparam logic [RFC_WD_W-1:0] RFC_WD_RELOAD_RST = 16'hffff;
	localparam logic [7:0]          RFC_WD_KEY        = 8'ha5;
	localparam int RFC_CFG_EN  = 0;
	localparam int RFC_CFG_RLD = 16;

	// Flags of register B that exist in the chosen variant.
	function automatic logic [RFC_B_W-1:0] rfc_b_impl(input logic variant);
		return RFC_B_COMMON | (variant ? RFC_B_ONLY_V2 : RFC_B_ONLY_V1);
	endfunction : rfc_b_impl

endpackage : rfc_pkg

// ==== hw/rfc_wdog_if.sv ====
// Carrier between the register front end and one watchdog counter.
`timescale 1ns/100ps
interface rfc_wdog_if;
	import rfc_pkg::*;
	logic                enable;
	logic [RFC_WD_W-1:0] reload;
	logic                refresh;
	logic                key_ok;
	logic                fire;

	modport ctl (output enable, output reload, output refresh, output key_ok, input fire);
	modport wd  (input enable, input reload, input refresh, input key_ok, output fire);
endinterface : rfc_wdog_if

// ==== hw/rfc_wdog.sv ====
// Watchdog down-counter that requests a reset on underflow or bad refresh.
`timescale 1ns/100ps
module rfc_wdog
	import rfc_pkg::*;
#(
	parameter bit WINDOWED = 1'b0
) (
	input wire logic clk,   // System clock.
	input wire logic rst_n, // Power-on reset, active low.
	rfc_wdog_if.wd   wdi    // Control and reset request.
);

	logic [RFC_WD_W-1:0] count_reg;
	logic [RFC_WD_W-1:0] count_next;
	logic                fire_reg;
	logic                fire_next;
	logic                early;

	// ------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------
	always_comb begin
		// A windowed dog refuses a refresh while above half the reload.
		early      = WINDOWED && (count_reg > (wdi.reload >> 1));
		count_next = count_reg;
		fire_next  = 1'b0;
		if (!wdi.enable) begin
			count_next = wdi.reload;
		end else if (wdi.refresh) begin
			count_next = wdi.reload;
			fire_next  = !wdi.key_ok || early;
		end else if (count_reg == '0) begin
			count_next = wdi.reload;
			fire_next  = 1'b1;
		end else begin
			count_next = count_reg - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_reg <= RFC_WD_RELOAD_RST;
			fire_reg  <= 1'b0;
		end else begin
			count_reg <= count_next;
			fire_reg  <= fire_next;
		end
	end

	assign wdi.fire = fire_reg;

endmodule : rfc_wdog

// ==== hw/rfc_reset_flags.sv ====
// Reset-cause flag retention and clearing with APB access and two watchdogs.
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/100ps
module rfc_reset_flags
	import rfc_pkg::*;
#(
	parameter bit VARIANT = 1'b0
) (
	input  wire logic        clk,             // System clock, 125 MHz.
	input  wire logic        rst_n,           // Power-on reset, active low.
	input  wire logic        psel,            // APB select.
	input  wire logic        penable,         // APB access phase.
	input  wire logic        pwrite,          // APB write.
	input  wire logic [7:0]  paddr,           // APB byte address.
	input  wire logic [31:0] pwdata,          // APB write data.
	output logic      [31:0] prdata,          // APB read data.
	output logic             pready,          // APB ready.
	output logic             pslverr,         // APB error on unmapped address.
	input  wire logic        pin_reset_evt,   // External pin reset event pulse.
	input  wire logic        vmon0_evt,       // Voltage monitor 0 reset pulse.
	input  wire logic        vmon1_evt,       // Voltage monitor 1 reset pulse.
	input  wire logic        vmon2_evt,       // Voltage monitor 2 reset pulse.
	input  wire logic        deep_stby_evt,   // Deep standby reset pulse.
	input  wire logic        soft_evt,        // Software reset pulse.
	input  wire logic        ram_par_evt,     // RAM parity reset pulse.
	input  wire logic        ram_ecc_evt,     // RAM ECC reset pulse.
	input  wire logic        bus_slave_evt,   // Bus slave protection pulse.
	input  wire logic        bus_master_evt,  // Bus master protection pulse.
	input  wire logic        stack_ptr_evt,   // Stack pointer error pulse.
	input  wire logic        sec_state_evt,   // Security state error pulse.
	input  wire logic        cache_par_evt,   // Cache parity error pulse.
	output logic             indep_wdog_rst,  // Independent watchdog reset request.
	output logic             window_wdog_rst  // Window watchdog reset request.
);

	logic [RFC_A_W-1:0]  cause_a_reg;
	logic [RFC_A_W-1:0]  cause_a_next;
	logic [RFC_B_W-1:0]  cause_b_reg;
	logic [RFC_B_W-1:0]  cause_b_next;
	logic                cold_warm_reg;
	logic                cold_warm_next;
	logic [31:0]         iwd_cfg_reg;
	logic [31:0]         iwd_cfg_next;
	logic [31:0]         wwd_cfg_reg;
	logic [31:0]         wwd_cfg_next;
	logic [31:0]         prdata_next;
	logic                pready_next;
	logic                pslverr_next;
	logic                iwd_rst_next;
	logic                wwd_rst_next;
	logic [RFC_A_W-1:0]  set_a;
	logic [RFC_B_W-1:0]  set_b;
	logic [RFC_A_W-1:0]  clr_a;
	logic [RFC_B_W-1:0]  clr_b;
	logic                wr_done;
	logic                access;

	rfc_wdog_if iwd_if ();
	rfc_wdog_if wwd_if ();

	// The two dogs differ only in the refresh window.
	rfc_wdog #(.WINDOWED(1'b0)) u_indep (.clk(clk), .rst_n(rst_n), .wdi(iwd_if.wd));
	rfc_wdog #(.WINDOWED(1'b1)) u_window (.clk(clk), .rst_n(rst_n), .wdi(wwd_if.wd));

	function automatic logic addr_known(input logic [7:0] a);
		return a == RFC_OFS_CAUSE_A || a == RFC_OFS_CAUSE_B || a == RFC_OFS_CAUSE_C
			|| a == RFC_OFS_IWD_CFG || a == RFC_OFS_WWD_CFG
			|| a == RFC_OFS_IWD_REFRSH || a == RFC_OFS_WWD_REFRSH;
	endfunction : addr_known

	// Passing every operand keeps continuous assignments sensitive to all of them.
	function automatic logic wr_hit(
		input logic       d,
		input logic [7:0] a,
		input logic [7:0] ofs
	);
		return d && a == ofs;
	endfunction : wr_hit

	// ------------------------------------------------------------
	// Watchdog control
	// ------------------------------------------------------------
	assign access          = psel && penable;
	assign wr_done         = access && pready && pwrite;
	assign iwd_if.enable   = iwd_cfg_reg[RFC_CFG_EN];
	assign iwd_if.reload   = iwd_cfg_reg[RFC_CFG_RLD +: RFC_WD_W];
	assign iwd_if.refresh  = wr_hit(wr_done, paddr, RFC_OFS_IWD_REFRSH);
	// Both dogs see the same key compare; only the address picks the one refreshed.
	assign iwd_if.key_ok   = pwdata[7:0] == RFC_WD_KEY;
	assign wwd_if.enable   = wwd_cfg_reg[RFC_CFG_EN];
	assign wwd_if.reload   = wwd_cfg_reg[RFC_CFG_RLD +: RFC_WD_W];
	assign wwd_if.refresh  = wr_hit(wr_done, paddr, RFC_OFS_WWD_REFRSH);
	assign wwd_if.key_ok   = pwdata[7:0] == RFC_WD_KEY;

	// ------------------------------------------------------------
	// Cause flags
	// ------------------------------------------------------------
	always_comb begin
		set_a = '0;
		set_b = '0;
		set_a[A_VMON0]      = vmon0_evt;
		set_a[A_VMON1]      = vmon1_evt;
		set_a[A_VMON2]      = vmon2_evt;
		set_a[A_DEEP_STBY]  = deep_stby_evt;
		set_b[B_INDEP_WDOG] = iwd_if.fire;
		set_b[B_WIN_WDOG]   = wwd_if.fire;
		set_b[B_SOFT]       = soft_evt;
		set_b[B_RAM_PAR]    = ram_par_evt;
		set_b[B_RAM_ECC]    = ram_ecc_evt;
		set_b[B_BUS_SLAVE]  = bus_slave_evt;
		set_b[B_BUS_MASTER] = bus_master_evt;
		set_b[B_STACK_PTR]  = stack_ptr_evt;
		set_b[B_SEC_STATE]  = sec_state_evt;
		set_b[B_CACHE_PAR]  = cache_par_evt;
		// Flags that a variant lacks are masked so they always read zero.
		set_b = set_b & rfc_b_impl(VARIANT);
		clr_a = '0;
		clr_b = '0;
		// The pin reset clears every other source's flag; it has no flag of its own.
		if (pin_reset_evt) begin
			clr_a = RFC_A_PIN_CLR;
			clr_b = RFC_B_PIN_COMN | (VARIANT ? RFC_B_ONLY_V2 : RFC_B_ONLY_V1);
		end
		// Software clears a flag by writing zero; a new event still wins.
		if (wr_hit(wr_done, paddr, RFC_OFS_CAUSE_A)) begin
			clr_a = clr_a | ~pwdata[RFC_A_W-1:0];
		end
		if (wr_hit(wr_done, paddr, RFC_OFS_CAUSE_B)) begin
			clr_b = clr_b | ~pwdata[RFC_B_W-1:0];
		end
		cause_a_next = (cause_a_reg & ~clr_a) | set_a;
		cause_b_next = (cause_b_reg & ~clr_b) | set_b;
		// The pin reset leaves this flag alone so a warm start is visible.
		cold_warm_next = cold_warm_reg;
		if (wr_hit(wr_done, paddr, RFC_OFS_CAUSE_C) && pwdata[C_COLD_WARM]) begin
			cold_warm_next = 1'b1;
		end
	end

	// Power-on is the only reset of this block, so it alone loads the reset values.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cause_a_reg   <= RFC_A_RESET;
			cause_b_reg   <= RFC_B_RESET;
			cold_warm_reg <= RFC_C_RESET;
		end else begin
			cause_a_reg   <= cause_a_next;
			cause_b_reg   <= cause_b_next;
			cold_warm_reg <= cold_warm_next;
		end
	end

	// ------------------------------------------------------------
	// Watchdog configuration and reset requests
	// ------------------------------------------------------------
	always_comb begin
		iwd_cfg_next = iwd_cfg_reg;
		wwd_cfg_next = wwd_cfg_reg;
		// A counter starts from the reload it held while disabled, so software
		// writes a new reload first and sets the enable bit in a second write.
		if (wr_hit(wr_done, paddr, RFC_OFS_IWD_CFG)) begin
			iwd_cfg_next = pwdata;
		end
		if (wr_hit(wr_done, paddr, RFC_OFS_WWD_CFG)) begin
			wwd_cfg_next = pwdata;
		end
		// One more register stage keeps the request pins straight off flip-flops.
		iwd_rst_next = iwd_if.fire;
		wwd_rst_next = wwd_if.fire;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			iwd_cfg_reg     <= {RFC_WD_RELOAD_RST, 16'h0000};
			wwd_cfg_reg     <= {RFC_WD_RELOAD_RST, 16'h0000};
			indep_wdog_rst  <= 1'b0;
			window_wdog_rst <= 1'b0;
		end else begin
			iwd_cfg_reg     <= iwd_cfg_next;
			wwd_cfg_reg     <= wwd_cfg_next;
			indep_wdog_rst  <= iwd_rst_next;
			window_wdog_rst <= wwd_rst_next;
		end
	end

	// ------------------------------------------------------------
	// APB slave: answers on the second access cycle
	// ------------------------------------------------------------
	always_comb begin
		pready_next  = 1'b0;
		pslverr_next = 1'b0;
		prdata_next  = '0;
		if (access && !pready) begin
			pready_next  = 1'b1;
			// Unmapped offsets answer with an error and read as zero.
			pslverr_next = !addr_known(paddr);
			if (!pwrite) begin
				unique case (paddr)
					RFC_OFS_CAUSE_A: prdata_next = {27'h0000000, cause_a_reg};
					RFC_OFS_CAUSE_B: prdata_next = {22'h000000, cause_b_reg};
					RFC_OFS_CAUSE_C: prdata_next = {31'h00000000, cold_warm_reg};
					RFC_OFS_IWD_CFG: prdata_next = iwd_cfg_reg;
					RFC_OFS_WWD_CFG: prdata_next = wwd_cfg_reg;
					default:         prdata_next = '0;
				endcase
			end
		end
	end

	// Read data returns to zero after the answer so a stale word never lingers.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata  <= '0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata  <= prdata_next;
			pready  <= pready_next;
			pslverr <= pslverr_next;
		end
	end

endmodule : rfc_reset_flags

// ==== bench/rfc_reset_flags_checker.sv ====
// Port-level checks for the reset-cause flag block.
`timescale 1ns/100ps
module rfc_reset_flags_checker
	import rfc_pkg::*;
(
	input wire logic        clk,             // Clock.
	input wire logic        rst_n,           // Reset.
	input wire logic        psel,            // Select.
	input wire logic        penable,         // Access.
	input wire logic        pwrite,          // Write.
	input wire logic [7:0]  paddr,           // Address.
	input wire logic [31:0] pwdata,          // Write data.
	input wire logic [31:0] prdata,          // Read data.
	input wire logic        pready,          // Ready.
	input wire logic        pslverr,         // Error.
	input wire logic        indep_wdog_rst,  // Watchdog request.
	input wire logic        window_wdog_rst  // Watchdog request.
);
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire done = psel & penable & pready;

	a_ready_next: assert property (psel && penable && !pready |=> pready) else $error("late ready");
	a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
	a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("read data not idle");
	a_refresh_zero: assert property (done && !pwrite && paddr == RFC_OFS_IWD_REFRSH
		|-> prdata == 32'h0) else $error("refresh read not zero");
	a_iwd_bad_key: assert property (done && pwrite && paddr == RFC_OFS_IWD_REFRSH
		&& pwdata[7:0] != RFC_WD_KEY |-> ##[1:3] indep_wdog_rst) else $error("no fire");
	a_wwd_bad_key: assert property (done && pwrite && paddr == RFC_OFS_WWD_REFRSH
		&& pwdata[7:0] != RFC_WD_KEY |-> ##[1:3] window_wdog_rst) else $error("no fire");
	a_iwd_pulse: assert property ($rose(indep_wdog_rst) |=> !indep_wdog_rst) else $error("long");
	a_wwd_pulse: assert property ($rose(window_wdog_rst) |=> !window_wdog_rst) else $error("long");
	c_err: cover property (pslverr);
	c_iwd: cover property (indep_wdog_rst);
	c_wwd: cover property (window_wdog_rst);
endmodule : rfc_reset_flags_checker

bind rfc_reset_flags rfc_reset_flags_checker u_chk (.clk(clk), .rst_n(rst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .indep_wdog_rst(indep_wdog_rst),
	.window_wdog_rst(window_wdog_rst));

// ==== bench/rfc_reset_flags_tb.sv ====
// Self-checking bench for the reset-cause flag block.
`timescale 1ns/100ps
module rfc_reset_flags_tb
	import rfc_pkg::*;
;
	logic        clk, rst_n, psel, penable, pwrite, pin, pready, pslverr, iwd, wwd, err_v;
	logic        pready2, pslverr2, iwd2, wwd2, err_v2;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd_v, rv, prdata2, rd_v2;
	logic [11:0] evt;
	int          mismatches, samples_checked, cyc, am, bm, bm2, cm, n;
	localparam int BIMPL  = int'(RFC_B_COMMON | RFC_B_ONLY_V1);
	localparam int BIMPL2 = int'(RFC_B_COMMON | RFC_B_ONLY_V2);

	rfc_reset_flags #(.VARIANT(1'b0)) u_dut (.clk(clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pin_reset_evt(pin), .vmon0_evt(evt[0]),
		.vmon1_evt(evt[1]), .vmon2_evt(evt[2]), .deep_stby_evt(evt[3]), .soft_evt(evt[4]),
		.ram_par_evt(evt[5]), .ram_ecc_evt(evt[6]), .bus_slave_evt(evt[7]),
		.bus_master_evt(evt[8]), .stack_ptr_evt(evt[9]), .sec_state_evt(evt[10]),
		.cache_par_evt(evt[11]), .indep_wdog_rst(iwd), .window_wdog_rst(wwd));
	// The second variant sees the same stimulus so both clear sets are checked.
	rfc_reset_flags #(.VARIANT(1'b1)) u_dut_v2 (.clk(clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata2),
		.pready(pready2), .pslverr(pslverr2), .pin_reset_evt(pin), .vmon0_evt(evt[0]),
		.vmon1_evt(evt[1]), .vmon2_evt(evt[2]), .deep_stby_evt(evt[3]), .soft_evt(evt[4]),
		.ram_par_evt(evt[5]), .ram_ecc_evt(evt[6]), .bus_slave_evt(evt[7]),
		.bus_master_evt(evt[8]), .stack_ptr_evt(evt[9]), .sec_state_evt(evt[10]),
		.cache_par_evt(evt[11]), .indep_wdog_rst(iwd2), .window_wdog_rst(wwd2));

	// ------------------------------------------------------------
	// Clock, timeout and helpers
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			results();
		end
	end
	task automatic results;
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : results
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// Every request starts one edge later, so back-to-back calls never double-drive.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd_v = prdata;
		err_v = pslverr;
		rd_v2 = prdata2;
		err_v2 = pslverr2;
		chk(32'(pready2), 32'h1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd_v, exp);
	endtask : rd
	task automatic check_all;
		rd(RFC_OFS_CAUSE_A, am);
		chk(rd_v2, am);
		rd(RFC_OFS_CAUSE_B, bm);
		chk(rd_v2, bm2);
		rd(RFC_OFS_CAUSE_C, cm);
		chk(rd_v2, cm);
	endtask : check_all
	task automatic pulse(input logic [11:0] e, input logic p);
		@(posedge clk);
		evt <= e;
		pin <= p;
		@(posedge clk);
		evt <= 12'h000;
		pin <= 1'b0;
	endtask : pulse
	task automatic wait_fire(input logic win, input int lim);
		n = 0;
		while ((win ? wwd : iwd) !== 1'b1 && n < lim) begin
			@(posedge clk);
			n++;
		end
		chk(32'(n < lim), 32'h1);
		chk(32'(win ? wwd2 : iwd2), 32'h1);
		bm |= win ? 2 : 1;
		bm2 |= win ? 2 : 1;
	endtask : wait_fire

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		{rst_n, psel, penable, pwrite, pin} = 5'h00;
		{paddr, pwdata, evt} = '0;
		void'($urandom(32'h4215b446));
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		am = 1;
		check_all();
		for (int i = 0; i < 12; i++) begin
			pulse(12'h001 << i, 1'b0);
			if (i < 4) begin
				am |= 1 << (i + 1);
			end else begin
				bm |= (1 << (i - 2)) & BIMPL;
				bm2 |= (1 << (i - 2)) & BIMPL2;
			end
		end
		check_all();
		apb(1'b1, RFC_OFS_CAUSE_C, 32'h1);
		cm = 1;
		for (int i = 0; i < 4; i++) begin
			rv = $urandom & 32'hffff_fffe;
			apb(1'b1, RFC_OFS_WWD_CFG, rv);
			rd(RFC_OFS_WWD_CFG, rv);
		end
		// The reload is loaded while disabled, then the dog is enabled.
		apb(1'b1, RFC_OFS_IWD_CFG, 32'h0010_0000);
		apb(1'b1, RFC_OFS_IWD_CFG, 32'h0010_0001);
		wait_fire(1'b0, 40);
		apb(1'b1, RFC_OFS_IWD_REFRSH, 32'h0000_005a);
		wait_fire(1'b0, 6);
		apb(1'b1, RFC_OFS_IWD_CFG, 32'h0);
		check_all();
		apb(1'b1, RFC_OFS_WWD_CFG, 32'h0100_0001);
		apb(1'b1, RFC_OFS_WWD_REFRSH, 32'h0);
		wait_fire(1'b1, 6);
		// A good key soon after a reload falls inside the closed window.
		apb(1'b1, RFC_OFS_CAUSE_B, 32'hffff_fffd);
		bm &= ~2;
		bm2 &= ~2;
		rd(RFC_OFS_CAUSE_B, bm);
		chk(rd_v2, bm2);
		apb(1'b1, RFC_OFS_WWD_REFRSH, {24'h000000, RFC_WD_KEY});
		wait_fire(1'b1, 6);
		apb(1'b1, RFC_OFS_WWD_CFG, 32'h0);
		check_all();
		rd(8'h40, 32'h0);
		chk(32'(err_v), 32'h1);
		chk(32'(err_v2), 32'h1);
		rd(RFC_OFS_IWD_REFRSH, 32'h0);
		pulse(12'h010, 1'b1);
		am = 0;
		bm = (bm & ~int'(RFC_B_PIN_COMN | RFC_B_ONLY_V1)) | 4;
		bm2 = (bm2 & ~int'(RFC_B_PIN_COMN | RFC_B_ONLY_V2)) | 4;
		check_all();
		pulse(12'hfff, 1'b0);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		am = 1;
		bm = 0;
		bm2 = 0;
		cm = 0;
		check_all();
		results();
	end
endmodule : rfc_reset_flags_tb
